// *** usp_pkg.sv ***
// Package: register map, field positions and reset values of the serial unit
package usp_pkg;
  // ************
  // Register map
  // ************
  localparam logic [2:0] ADR_FMT = 3'h0;
  localparam logic [2:0] ADR_CTL = 3'h1;
  localparam logic [2:0] ADR_TXH = 3'h2;
  localparam logic [2:0] ADR_STAT = 3'h3;
  localparam logic [2:0] ADR_RXH = 3'h4;
  localparam logic [2:0] ADR_LINE = 3'h5;
  // *****************************
  // Format register field positions
  // *****************************
  localparam int FMT_STOP2 = 0;
  localparam int FMT_MP = 1;
  localparam int FMT_ODD = 2;
  localparam int FMT_PE = 3;
  localparam int FMT_CHR7 = 4;
  // ******************************
  // Control register field positions
  // ******************************
  localparam int CTL_MPF = 1;
  localparam int CTL_TX_DONE_IRQ_EN = 2;
  localparam int CTL_RE = 4;
  localparam int CTL_TE = 5;
  localparam int CTL_RIE = 6;
  localparam int CTL_TIE = 7;
  // *****************************
  // Status and line register field positions
  // *****************************
  localparam int ST_ADDR_MARK_TX_BIT = 0;
  localparam int ST_MPB = 1;
  localparam int ST_TX_DONE_FLAG = 2;
  localparam int ST_PER = 3;
  localparam int ST_FER = 4;
  localparam int ST_OVERRUN_FLAG = 5;
  localparam int ST_RX_BUFFER_FULL_FLAG = 6;
  localparam int ST_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int LINE_RXD = 0;
  // ************
  // Reset values
  // ************
  localparam logic [4:0] FMT_RST = 5'h00;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // **************************************
  // Bit timing in ticks of the 16x clock
  // **************************************
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_SAMPLE = 4'h7;
  localparam logic [2:0] LAST_BIT8 = 3'h7;
  localparam logic [2:0] LAST_BIT7 = 3'h6;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP} usp_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} usp_rx_t;
endpackage

// *** usp_serial_unit.sv ***
// Serial unit: asynchronous transmitter and receiver with multiprocessor framing
// What this block does
// RL1 - Cleared empty flag means load holding into shifter
// RL2 - After load set empty flag, start, raise irq
// RL3 - Frame starts low, 7/8 data LSB first
// RL4 - Then parity or mark bit, stop bits, idle high
// RL5 - At stop, chain next byte or set done
// RL6 - Multiprocessor format sends address-mark bit
// RL7 - Software disables transmitter, then makes break via port
// RL8 - Receiver syncs on start, shifts LSB first
// RL9 - Check data parity against odd/even select
// RL10 - Stop bit must be one; first only
// RL11 - Clean frame goes to holding, full flag set
// RL12 - Frame while full sets overrun, byte dropped
// RL13 - Parity or framing error flags, byte still stored
// RL14 - Any error flag blocks reception until cleared
// RL15 - Receive full and error interrupts under enable
// RL16 - Software empties holding before next stop bit
// RL17 - DMA write/read clears empty/full flags automatically
// RL18 - Receive pin level readable by software
// RL19 - Send identifier marked, then payload unmarked
// RL20 - Skip frames until marked identifier matches
// RL21 - Multiprocessor formats ignore parity settings
// RL22 - Software writes data, mark bit, clears empty flag
// RL23 - Sync on start edge, sample eighth tick
// RL24 - Transmit disable resets shifter; receive disable keeps flags
// RL25 - Line idles high; format from settings
// RL26 - Received address-mark bit readable as status
`timescale 1ns/1ns
module usp_serial_unit
  import usp_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic TICK16,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic DMA_TX_WR,
  input wire logic [7:0] DMA_TX_DATA,
  input wire logic DMA_RX_RD,
  output logic [7:0] DMA_RX_DATA,
  input wire logic RXD,
  output logic TXD,
  output logic TXD_EN,
  output logic TX_EMPTY_IRQ,
  output logic TX_DONE_IRQ,
  output logic RX_FULL_IRQ,
  output logic RX_ERR_IRQ
);
  // ***********
  // State record
  // ***********
  typedef struct packed {
    logic [4:0] fmt;
    logic [7:0] ctl;
    logic [7:0] tx_holding_reg;
    logic [7:0] tx_shift_reg;
    usp_tx_t tx_st;
    logic [3:0] tx_cnt;
    logic [2:0] tx_bit;
    logic tx_x;
    logic tx_buffer_empty_flag;
    logic tx_done_flag;
    logic addr_mark_tx_bit;
    logic txd;
    usp_rx_t rx_st;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift_reg;
    logic rx_x;
    logic [7:0] rx_holding_reg;
    logic rx_buffer_full_flag;
    logic overrun_flag;
    logic framing_fault_flag;
    logic per;
    logic addr_mark_bit;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    logic [7:0] rdata;
  } usp_state_t;

  usp_state_t s_q;
  usp_state_t s_d;

  function automatic logic [2:0] last_bit(input logic chr7);
    last_bit = chr7 ? LAST_BIT7 : LAST_BIT8;
  endfunction

  function automatic logic [7:0] mask_data(input logic [7:0] d, input logic chr7);
    mask_data = chr7 ? {1'b0, d[6:0]} : d;
  endfunction

  logic te;
  logic re;
  logic mp;
  logic has_x;
  logic errs;
  logic tx_end;
  logic rx_tick;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic stop_ok;
  logic par_bad;

  always_comb begin
    te = s_q.ctl[CTL_TE];
    re = s_q.ctl[CTL_RE];
    mp = s_q.fmt[FMT_MP];
    has_x = mp | s_q.fmt[FMT_PE]; // RL21
    errs = s_q.overrun_flag | s_q.framing_fault_flag | s_q.per;
    tx_end = TICK16 && (s_q.tx_cnt == TICK_LAST);
    rx_tick = TICK16 && (s_q.rx_cnt == TICK_SAMPLE);
    tx_data = mask_data(s_q.tx_holding_reg, s_q.fmt[FMT_CHR7]);
    rx_data = s_q.fmt[FMT_CHR7] ? {1'b0, s_q.rx_shift_reg[7:1]} : s_q.rx_shift_reg;
    stop_ok = s_q.rx_s2; // RL10
    par_bad = (^{rx_data, s_q.rx_x}) != s_q.fmt[FMT_ODD]; // RL9
  end

  always_comb begin
    s_d = s_q;
    // Pin synchroniser; second stage is the only reader of the first
    s_d.rx_s1 = RXD;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.rx_prev = s_q.rx_s2;

    // ********************
    // Register writes
    // ********************
    if (WR) begin
      unique case (ADDR)
        ADR_FMT: s_d.fmt = WDATA[4:0];
        ADR_CTL: s_d.ctl = WDATA;
        ADR_TXH: s_d.tx_holding_reg = WDATA;
        ADR_STAT: begin
          // Flags clear on a written 0, done only through the empty bit; a written 1 leaves them alone
          if (!WDATA[ST_TX_BUFFER_EMPTY_FLAG]) begin
            s_d.tx_buffer_empty_flag = 1'b0;
            s_d.tx_done_flag = 1'b0;
          end
          if (!WDATA[ST_RX_BUFFER_FULL_FLAG]) s_d.rx_buffer_full_flag = 1'b0;
          if (!WDATA[ST_OVERRUN_FLAG]) s_d.overrun_flag = 1'b0; // RL14
          if (!WDATA[ST_FER]) s_d.framing_fault_flag = 1'b0;
          if (!WDATA[ST_PER]) s_d.per = 1'b0;
          s_d.addr_mark_tx_bit = WDATA[ST_ADDR_MARK_TX_BIT]; // RL22
        end
        default: ;
      endcase
    end
    if (DMA_TX_WR) begin
      s_d.tx_holding_reg = DMA_TX_DATA; // RL17
      s_d.tx_buffer_empty_flag = 1'b0; // RL17
      s_d.tx_done_flag = 1'b0;
    end
    if (DMA_RX_RD) s_d.rx_buffer_full_flag = 1'b0; // RL17

    // ********************
    // Register reads
    // ********************
    if (RD) begin
      unique case (ADDR)
        ADR_FMT: s_d.rdata = {3'h0, s_q.fmt};
        ADR_CTL: s_d.rdata = s_q.ctl;
        ADR_TXH: s_d.rdata = s_q.tx_holding_reg;
        ADR_STAT: s_d.rdata = {s_q.tx_buffer_empty_flag, s_q.rx_buffer_full_flag, s_q.overrun_flag, s_q.framing_fault_flag, s_q.per,
                               s_q.tx_done_flag, s_q.addr_mark_bit, s_q.addr_mark_tx_bit}; // RL26
        ADR_RXH: s_d.rdata = s_q.rx_holding_reg;
        ADR_LINE: s_d.rdata = {7'h00, s_q.rx_s2}; // RL18
        default: s_d.rdata = 8'h00;
      endcase
    end

    // ********************
    // Transmitter
    // ********************
    if (TICK16 && s_q.tx_st != TX_IDLE) s_d.tx_cnt = s_q.tx_cnt + 4'h1;
    if (!te) begin
      // Disable drops the frame at once and reports the buffer free
      s_d.tx_st = TX_IDLE; // RL24
      s_d.tx_shift_reg = BYTE_RST; // RL24
      s_d.tx_buffer_empty_flag = 1'b1; // RL24
      s_d.tx_cnt = 4'h0;
    end else begin
      unique case (s_q.tx_st)
        TX_IDLE: begin
          if (!s_q.tx_buffer_empty_flag) begin
            s_d.tx_shift_reg = tx_data; // RL1
            s_d.tx_x = mp ? s_q.addr_mark_tx_bit : (^tx_data) ^ s_q.fmt[FMT_ODD]; // RL6
            s_d.tx_buffer_empty_flag = 1'b1; // RL2
            s_d.tx_done_flag = 1'b0;
            s_d.tx_cnt = 4'h0;
            s_d.tx_st = TX_START;
          end
        end
        TX_START: begin
          if (tx_end) begin
            s_d.tx_bit = 3'h0;
            s_d.tx_st = TX_DATA; // RL3
          end
        end
        TX_DATA: begin
          if (tx_end) begin
            s_d.tx_shift_reg = {1'b0, s_q.tx_shift_reg[7:1]}; // RL3
            s_d.tx_bit = s_q.tx_bit + 3'h1;
            if (s_q.tx_bit == last_bit(s_q.fmt[FMT_CHR7])) begin
              s_d.tx_bit = 3'h0;
              s_d.tx_st = has_x ? TX_EXTRA : TX_STOP; // RL4
            end
          end
        end
        TX_EXTRA: begin
          if (tx_end) begin
            s_d.tx_bit = 3'h0;
            s_d.tx_st = TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_end) begin
            if (s_q.tx_bit == 3'h0 && s_q.fmt[FMT_STOP2]) begin
              s_d.tx_bit = 3'h1; // RL4
            end else if (!s_q.tx_buffer_empty_flag) begin
              s_d.tx_shift_reg = tx_data; // RL5
              s_d.tx_x = mp ? s_q.addr_mark_tx_bit : (^tx_data) ^ s_q.fmt[FMT_ODD];
              s_d.tx_buffer_empty_flag = 1'b1; // RL2
              s_d.tx_st = TX_START; // RL5
            end else begin
              s_d.tx_done_flag = 1'b1; // RL5
              s_d.tx_st = TX_IDLE;
            end
          end
        end
      endcase
    end
    // Line level registered from the next state
    unique case (s_d.tx_st)
      TX_START: s_d.txd = 1'b0; // RL3
      TX_DATA: s_d.txd = s_d.tx_shift_reg[0];
      TX_EXTRA: s_d.txd = s_d.tx_x; // RL6
      default: s_d.txd = 1'b1; // RL25
    endcase

    // ********************
    // Receiver
    // ********************
    if (TICK16) s_d.rx_cnt = s_q.rx_cnt + 4'h1;
    // Disable stops reception only; flags and holding byte stay
    if (!re) begin
      s_d.rx_st = RX_IDLE; // RL24
    end else begin
      unique case (s_q.rx_st)
        RX_IDLE: begin
          // Errors hold the receiver off until software clears them
          if (!errs && s_q.rx_prev && !s_q.rx_s2) begin
            s_d.rx_cnt = 4'h0; // RL23
            s_d.rx_st = RX_START; // RL8
          end
        end
        RX_START: begin
          if (rx_tick) begin
            // A glitch shorter than half a bit is not a start
            s_d.rx_st = s_q.rx_s2 ? RX_IDLE : RX_DATA;
            s_d.rx_bit = 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            s_d.rx_shift_reg = {s_q.rx_s2, s_q.rx_shift_reg[7:1]}; // RL8
            s_d.rx_bit = s_q.rx_bit + 3'h1;
            if (s_q.rx_bit == last_bit(s_q.fmt[FMT_CHR7])) begin
              s_d.rx_st = has_x ? RX_EXTRA : RX_STOP;
            end
          end
        end
        RX_EXTRA: begin
          if (rx_tick) begin
            s_d.rx_x = s_q.rx_s2;
            s_d.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            // Second stop bit is never waited for
            s_d.rx_st = RX_IDLE; // RL10
            if (!mp) s_d.rx_x = 1'b0;
            if (mp && s_q.ctl[CTL_MPF] && !s_q.rx_x) begin
              // Unmarked frame while skipping: dropped silently
              s_d.rx_st = RX_IDLE; // RL20
            end else if (s_q.rx_buffer_full_flag) begin
              s_d.overrun_flag = 1'b1; // RL12
            end else begin
              s_d.rx_holding_reg = rx_data; // RL11
              s_d.addr_mark_bit = mp & s_q.rx_x; // RL26
              if (mp) s_d.ctl[CTL_MPF] = 1'b0; // RL20
              s_d.framing_fault_flag = !stop_ok; // RL13
              s_d.per = !mp && s_q.fmt[FMT_PE] && par_bad; // RL13
              s_d.rx_buffer_full_flag = stop_ok && !(!mp && s_q.fmt[FMT_PE] && par_bad); // RL11
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
      s_q.fmt <= FMT_RST;
      s_q.ctl <= CTL_RST;
      s_q.tx_st <= TX_IDLE;
      s_q.rx_st <= RX_IDLE;
      s_q.tx_buffer_empty_flag <= 1'b1;
      s_q.tx_done_flag <= 1'b1;
      s_q.txd <= 1'b1;
      s_q.rx_s1 <= 1'b1;
      s_q.rx_s2 <= 1'b1;
      s_q.rx_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************
  // Outputs
  // ********************
  assign RDATA = s_q.rdata;
  assign DMA_RX_DATA = s_q.rx_holding_reg;
  assign TXD = s_q.txd; // RL25
  assign TXD_EN = te; // RL7
  assign TX_EMPTY_IRQ = s_q.ctl[CTL_TIE] & s_q.tx_buffer_empty_flag; // RL2
  assign TX_DONE_IRQ = s_q.ctl[CTL_TX_DONE_IRQ_EN] & s_q.tx_done_flag; // RL5
  assign RX_FULL_IRQ = s_q.ctl[CTL_RIE] & s_q.rx_buffer_full_flag; // RL15
  assign RX_ERR_IRQ = s_q.ctl[CTL_RIE] & errs; // RL15
endmodule

// *** usp_serial_unit_monitor.sv ***
// Port checker of the serial unit
`timescale 1ns/1ns
module usp_serial_unit_monitor
  import usp_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic DMA_TX_WR,
  input wire logic DMA_RX_RD,
  input wire logic TXD,
  input wire logic TXD_EN,
  input wire logic TX_EMPTY_IRQ,
  input wire logic TX_DONE_IRQ,
  input wire logic RX_FULL_IRQ,
  input wire logic RX_ERR_IRQ
);
  // ****
  // Rules
  // ****
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence ctl_wr;
    WR && ADDR == ADR_CTL;
  endsequence
  // Idle only known through done level
  sequence tx_kick;
    WR && ADDR == ADR_STAT && !WDATA[ST_TX_BUFFER_EMPTY_FLAG] && TX_DONE_IRQ && TXD_EN;
  endsequence
  unmapped_read_a: assert property (RD && ADDR > ADR_LINE |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!RD |=> $stable(RDATA))
    else $error("read data moved");
  tx_start_a: assert property (tx_kick |-> ##[1:2] !TXD)
    else $error("no start bit");
  tx_enable_a: assert property (ctl_wr |=> TXD_EN == $past(WDATA[CTL_TE]))
    else $error("enable wrong");
  idle_high_a: assert property (!TXD_EN [*2] |-> TXD)
    else $error("line not idle high");
  empty_mask_a: assert property (ctl_wr ##0 !WDATA[CTL_TIE] |=> !TX_EMPTY_IRQ)
    else $error("empty irq unmasked");
  done_mask_a: assert property (ctl_wr ##0 !WDATA[CTL_TX_DONE_IRQ_EN] |=> !TX_DONE_IRQ)
    else $error("done irq unmasked");
  rx_mask_a: assert property (ctl_wr ##0 !WDATA[CTL_RIE] |=> !(RX_FULL_IRQ || RX_ERR_IRQ))
    else $error("rx irq unmasked");
  dma_rx_a: assert property (DMA_RX_RD |=> !RX_FULL_IRQ)
    else $error("full not cleared");
  dma_tx_a: assert property (DMA_TX_WR |=> !TX_EMPTY_IRQ)
    else $error("empty not cleared");
endmodule
bind usp_serial_unit usp_serial_unit_monitor mon (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DMA_TX_WR(DMA_TX_WR),
  .DMA_RX_RD(DMA_RX_RD), .TXD(TXD), .TXD_EN(TXD_EN), .TX_EMPTY_IRQ(TX_EMPTY_IRQ),
  .TX_DONE_IRQ(TX_DONE_IRQ), .RX_FULL_IRQ(RX_FULL_IRQ), .RX_ERR_IRQ(RX_ERR_IRQ));

// *** usp_line_partner.sv ***
// Remote station: drives the receive line, captures sent frames
`timescale 1ns/1ns
module usp_line_partner (
  input wire logic clk,
  input wire logic tick,
  input wire logic txd,
  output logic rxd
);
  int nbits = 9;
  logic [10:0] got_q[$];
  logic [10:0] w;
  initial rxd = 1'b1;
  task automatic bit_time(logic b);
    rxd <= b;
    repeat (16) @(posedge clk iff tick);
  endtask
  // Last bit is held, so a zero stop bit leaves a break
  task automatic send(logic [10:0] b, int n);
    @(posedge clk);
    bit_time(1'b1);
    bit_time(1'b0);
    for (int i = 0; i < n; i++) bit_time(b[i]);
  endtask
  always begin
    @(negedge txd);
    repeat (8) @(posedge clk iff tick);
    w = '0;
    for (int i = 0; i < nbits; i++) begin
      repeat (16) @(posedge clk iff tick);
      w[i] = txd;
    end
    got_q.push_back(w);
  end
endmodule

// *** tb_async_uart_multiproc.sv ***
// Testbench of the serial unit
`timescale 1ns/1ns
module tb_async_uart_multiproc;
  import usp_pkg::*;
  logic CLK = 0, RSTN = 0, TICK16 = 0, WR = 0, RD = 0, DMA_TX_WR = 0, DMA_RX_RD = 0;
  logic [2:0] ADDR = 0;
  logic [7:0] WDATA = 0, DMA_TX_DATA = 0, RDATA, DMA_RX_DATA, v, d, d2;
  logic RXD, TXD, TXD_EN, TX_EMPTY_IRQ, TX_DONE_IRQ, RX_FULL_IRQ, RX_ERR_IRQ;
  logic [10:0] e1, e2;
  logic [4:0] fmts [4] = '{5'h08, 5'h0C, 5'h11, 5'h0E};
  int num_errors = 0, total_checks = 0, seed = 4274, tc = 0, n;
  usp_serial_unit dut (.CLK(CLK), .RSTN(RSTN), .TICK16(TICK16), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .DMA_TX_WR(DMA_TX_WR), .DMA_TX_DATA(DMA_TX_DATA),
    .DMA_RX_RD(DMA_RX_RD), .DMA_RX_DATA(DMA_RX_DATA), .RXD(RXD), .TXD(TXD), .TXD_EN(TXD_EN),
    .TX_EMPTY_IRQ(TX_EMPTY_IRQ), .TX_DONE_IRQ(TX_DONE_IRQ), .RX_FULL_IRQ(RX_FULL_IRQ),
    .RX_ERR_IRQ(RX_ERR_IRQ));
  usp_line_partner line (.clk(CLK), .tick(TICK16), .txd(TXD), .rxd(RXD));
  initial forever #10 CLK = ~CLK;
  // ****
  // Short bits keep the run small
  // ****
  always @(posedge CLK) begin
    tc <= (tc + 1) % 4;
    TICK16 <= tc == 3;
  end
  task automatic chk_reg(string s, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_frame(string s, logic [10:0] e, logic [10:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] x);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= x;
    WR <= 1;
    @(posedge CLK);
    WR <= 0;
  endtask
  task automatic rd(logic [2:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1;
    @(posedge CLK);
    RD <= 0;
    @(negedge CLK);
    v = RDATA;
  endtask
  function automatic int frame(logic [4:0] f, logic [7:0] x, logic m, output logic [10:0] b);
    int k;
    k = f[FMT_CHR7] ? 7 : 8;
    b = f[FMT_CHR7] ? {4'h0, x[6:0]} : {3'h0, x};
    if (f[FMT_MP]) b[k] = m;
    else if (f[FMT_PE]) b[k] = ^b[7:0] ^ f[FMT_ODD];
    if (f[FMT_MP] || f[FMT_PE]) k++;
    b[k] = 1'b1;
    return k + 1;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    // About four times the expected run, well under the cycle budget
    #1000000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge CLK);
    RSTN <= 1;
    rd(ADR_STAT);
    chk_reg("status", 8'h84, v);
    rd(3'h7);
    chk_reg("unmapped", 8'h00, v);
    wr(ADR_CTL, 8'hF4);
    foreach (fmts[i]) begin
      wr(ADR_FMT, {3'h0, fmts[i]});
      d = $random(seed);
      d2 = $random(seed);
      n = frame(fmts[i], d, i[0], e1);
      n = frame(fmts[i], d2, i[0], e2);
      line.nbits = n;
      wr(ADR_TXH, d);
      wr(ADR_STAT, {5'h0F, 2'h0, i[0]});
      rd(ADR_STAT);
      chk_reg("empty", 8'h81, {v[7], 6'h0, TX_EMPTY_IRQ});
      @(posedge CLK);
      DMA_TX_DATA <= d2;
      DMA_TX_WR <= 1;
      @(posedge CLK);
      DMA_TX_WR <= 0;
      for (int k = 0; k < 9000 && line.got_q.size() < 2; k++) @(posedge CLK);
      chk_frame("tx first", e1, line.got_q[0]);
      chk_frame("tx chained", e2, line.got_q[1]);
      line.got_q.delete();
      repeat (200) @(posedge CLK);
      chk_reg("done irq", 8'h01, {7'h0, TX_DONE_IRQ});
    end
    // Break: port takes the pin once the transmitter lets go of it
    wr(ADR_CTL, 8'h10);
    rd(ADR_STAT);
    chk_reg("tx released", 8'h81, {v[7], 6'h0, TXD});
    chk_reg("tx pin free", 8'h00, {7'h0, TXD_EN});
    wr(ADR_CTL, 8'hF6);
    wr(ADR_FMT, 8'h02);
    for (int k = 0; k < 2; k++) begin
      d = $random(seed);
      n = frame(5'h02, d, k[0], e1);
      line.send(e1, n);
    end
    rd(ADR_STAT);
    chk_reg("marked", 8'h42, v & 8'h7A);
    rd(ADR_RXH);
    chk_reg("rx byte", d, v);
    chk_reg("full irq", 8'h01, {7'h0, RX_FULL_IRQ});
    @(posedge CLK);
    DMA_RX_RD <= 1;
    @(posedge CLK);
    DMA_RX_RD <= 0;
    wr(ADR_FMT, 8'h08);
    for (int k = 0; k < 2; k++) begin
      d2 = $random(seed);
      n = frame(5'h08, d2, 1'b0, e1);
      e1[k + 8] = ~e1[k + 8];
      line.send(e1, n);
      rd(ADR_RXH);
      chk_reg("err byte", d2, v);
      rd(ADR_STAT);
      chk_reg("err flag", k ? 8'h10 : 8'h08, v & 8'h78);
      chk_reg("err irq", 8'h01, {7'h0, RX_ERR_IRQ});
      rd(ADR_LINE);
      chk_reg("line", {7'h0, ~k[0]}, v & 8'h01);
      n = frame(5'h08, d, 1'b0, e1);
      line.send(e1, n);
      rd(ADR_RXH);
      chk_reg("blocked", d2, v);
      wr(ADR_STAT, 8'h80);
    end
    n = frame(5'h08, d, 1'b0, e1);
    line.send(e1, n);
    line.send(e1 ^ 11'h0FF, n);
    rd(ADR_STAT);
    chk_reg("overrun", 8'h60, v & 8'h78);
    chk_reg("kept", d, DMA_RX_DATA);
    wr(ADR_STAT, 8'h80);
    wr(ADR_FMT, 8'h1C);
    n = frame(5'h1C, d2, 1'b0, e1);
    line.send(e1, n);
    rd(ADR_RXH);
    chk_reg("rx odd7", {1'b0, d2[6:0]}, v);
    rd(ADR_STAT);
    chk_reg("odd7 flags", 8'h40, v & 8'h78);
    report_and_stop();
  end
endmodule
